// File: rtl/snr_regs.vh
// Constants for the serial NOR command front end
// Overview of operation
// - Accept 4-byte plain, fast and double-rate fast reads with a 32-bit address.
// - Decode dual-lane 4-byte reads: output-only, I/O single rate, I/O double rate.
// - Decode quad-lane 4-byte reads: output-only, I/O single rate, I/O double rate.
// - Address width comes from a nonvolatile setting or enter/exit 4-byte commands.
// - Address bits are sampled on rising serial clock edges, and on both edges in double rate.
// - Read data starts at the address, which increments after every byte.
// - Dedicated 4-byte and double-rate commands ignore configuration; others follow it. All still widen their lanes to the PROTO_MODE width.
// - Without select rising right after the command byte, no latch or address-width command is executed.
// - Write enable sets the write enable latch.
// - Write disable clears the latch unless a protection error holds it set.
// - Register reads: lane 0 in, lane 1 out; dual uses 1:0; quad 3:0.
// - Select high ends any register read and stops output drive at once.
// - Status and flag status are readable continuously at any time.
// - Nonvolatile read gives 16 bits then zeros; reserved fields read as one.
// - Nonvolatile configuration is sent least significant byte first.
// - Volatile, enhanced volatile and extended address reads repeat one byte.
// - By default reads take a 24-bit address.
`ifndef SNR_REGS_VH
`define SNR_REGS_VH

`define SNR_OP_READ3      8'h03
`define SNR_OP_READ4      8'h13
`define SNR_OP_FAST3      8'h0b
`define SNR_OP_FAST4      8'h0c
`define SNR_OP_DFAST3     8'h0d
`define SNR_OP_DFAST4     8'h0e
`define SNR_OP_DOUT3      8'h3b
`define SNR_OP_DOUT4      8'h3c
`define SNR_OP_DDOUT3     8'h3d
`define SNR_OP_DIO3       8'hbb
`define SNR_OP_DIO4       8'hbc
`define SNR_OP_DDIO3      8'hbd
`define SNR_OP_DDIO4      8'hbe
`define SNR_OP_QOUT3      8'h6b
`define SNR_OP_QOUT4      8'h6c
`define SNR_OP_DQOUT3     8'h6d
`define SNR_OP_QIO3       8'heb
`define SNR_OP_QIO4       8'hec
`define SNR_OP_DQIO3      8'hed
`define SNR_OP_DQIO4      8'hee
`define SNR_OP_WR_EN      8'h06
`define SNR_OP_WR_DIS     8'h04
`define SNR_OP_RD_STAT    8'h05
`define SNR_OP_RD_FLAG    8'h70
`define SNR_OP_RD_NVC     8'hb5
`define SNR_OP_RD_VC      8'h85
`define SNR_OP_RD_EVC     8'h65
`define SNR_OP_RD_EXTA    8'hc8
`define SNR_OP_ADDR4_ON   8'hb7
`define SNR_OP_ADDR4_OFF  8'he9

`define SNR_DUMMY_DEF     8
`define SNR_NVC_RSVD      16'h0000
`define SNR_NVC_ADDR_BIT  0
`define SNR_ADDR_BITS3    6'h18
`define SNR_ADDR_BITS4    6'h20

`endif

// File: rtl/snr_sync.v
// Two-flop synchroniser for pin inputs
`timescale 1ns/10ps
module snr_sync #(
  parameter             WIDTH   = 6,
  parameter [WIDTH-1:0] RST_VAL = {WIDTH{1'b0}}
) (
  // Clock and reset
  input  wire             clk,
  input  wire             rst_n,
  // Data
  input  wire [WIDTH-1:0] din,
  output reg  [WIDTH-1:0] dout
);
  reg [WIDTH-1:0] meta;

  // Only the second stage is visible to other logic
  always @(posedge clk) begin
    if (!rst_n) begin
      meta <= RST_VAL;
      dout <= RST_VAL;
    end else begin
      meta <= din;
      dout <= meta;
    end
  end
endmodule // snr_sync

// File: rtl/snr_cmd_front.v
// Serial NOR read, write-latch and register-read command front end
`timescale 1ns/10ps
`include "snr_regs.vh"
module snr_cmd_front #(
  parameter        DUMMY_CLKS = `SNR_DUMMY_DEF,
  parameter [15:0] NVC_RSVD   = `SNR_NVC_RSVD
) (
  // Clock and reset
  input  wire        CLOCK,
  input  wire        RST_N,
  // Serial link
  input  wire        SCLK,
  input  wire        CS_N,
  input  wire [3:0]  LANE_IN,
  output reg  [3:0]  LANE_OUT,
  output reg  [3:0]  LANE_OE_N,
  // Configuration
  input  wire [1:0]  PROTO_MODE,
  input  wire        DTR_EN,
  input  wire [7:0]  STATUS_REG,
  input  wire [7:0]  FLAG_REG,
  input  wire [15:0] NVC_REG,
  input  wire [7:0]  VC_REG,
  input  wire [7:0]  EVC_REG,
  input  wire [7:0]  EXTA_REG,
  input  wire        PROT_ERR,
  input  wire        FLAG_CLEAR,
  // Array access
  output reg  [31:0] MEM_ADDR,
  input  wire [7:0]  MEM_DATA,
  // Status
  output reg         WEL,
  output reg         ADDR4_MODE
);
  localparam [5:0] ST_CMD    = 6'h01;
  localparam [5:0] ST_ADDR   = 6'h02;
  localparam [5:0] ST_DUMMY  = 6'h04;
  localparam [5:0] ST_OUT    = 6'h08;
  localparam [5:0] ST_HOLD   = 6'h10;
  localparam [5:0] ST_IGNORE = 6'h20;
  localparam [7:0] DUMMY_N   = DUMMY_CLKS;

  wire [5:0] sync_out;
  wire       sclk_s;
  wire       cs_n_s;
  wire [3:0] lane_s;
  wire       serial_lane_zero;

  reg  [5:0]  state;
  reg         sclk_d;
  reg         cs_n_d;
  reg  [31:0] in_sh;
  reg  [5:0]  bit_cnt;
  reg  [7:0]  cmd;
  reg  [1:0]  a_l;
  reg  [1:0]  o_l;
  reg         ddr;
  reg         mem_rd;
  reg  [5:0]  alen;
  reg  [7:0]  dummy_cnt;
  reg  [7:0]  out_sh;
  reg  [3:0]  out_cnt;
  reg  [1:0]  byte_idx;
  reg         reload;
  reg         started;
  reg         armed;
  reg         strap_load;

  reg  [31:0] next_sh;
  reg  [3:0]  drv;
  reg  [3:0]  oe_n;
  reg  [7:0]  next_out_sh;
  reg         next_wel;

  snr_sync #(
    .WIDTH   (6),
    .RST_VAL (6'h02)
  ) u_sync (
    .clk   (CLOCK),
    .rst_n (RST_N),
    .din   ({LANE_IN, CS_N, SCLK}),
    .dout  (sync_out)
  );

  assign sclk_s           = sync_out[0];
  assign cs_n_s           = sync_out[1];
  assign lane_s           = sync_out[5:2];
  assign serial_lane_zero = lane_s[0];

  wire samp_rise = sclk_s & ~sclk_d;
  wire samp_fall = ~sclk_s & sclk_d;
  wire cs_rise   = cs_n_s & ~cs_n_d;
  // Command width follows the protocol: 0 one lane, 1 two, 2 four
  wire [1:0] cw_l = (PROTO_MODE == 2'd2) ? 2'd2 : (PROTO_MODE == 2'd1) ? 2'd1 : 2'd0;
  wire [1:0] in_l = state[1] ? a_l : cw_l;
  wire [5:0] in_w = 6'd1 << in_l;
  wire [3:0] out_w = 4'd1 << o_l;
  wire       cmd_edge = samp_rise | (DTR_EN & samp_fall);
  wire       addr_edge = samp_rise | (ddr & (bit_cnt != 6'h0) & samp_fall);
  // First output bit always goes out on a falling edge
  wire       out_edge = samp_fall | (ddr & started & samp_rise);
  wire [5:0] bits_now = bit_cnt + in_w;
  wire [15:0] nvc_val = NVC_REG | NVC_RSVD;

  // {valid, plain, four-byte, double rate, address lanes, data lanes}
  function [7:0] dec_read;
    input [7:0] c;
    begin
      case (c)
        `SNR_OP_READ3:  dec_read = 8'hc0;
        `SNR_OP_READ4:  dec_read = 8'he0;
        `SNR_OP_FAST3:  dec_read = 8'h80;
        `SNR_OP_FAST4:  dec_read = 8'ha0;
        `SNR_OP_DFAST3: dec_read = 8'h90;
        `SNR_OP_DFAST4: dec_read = 8'hb0;
        `SNR_OP_DOUT3:  dec_read = 8'h81;
        `SNR_OP_DOUT4:  dec_read = 8'ha1;
        `SNR_OP_DDOUT3: dec_read = 8'h91;
        `SNR_OP_DIO3:   dec_read = 8'h85;
        `SNR_OP_DIO4:   dec_read = 8'ha5;
        `SNR_OP_DDIO3:  dec_read = 8'h95;
        `SNR_OP_DDIO4:  dec_read = 8'hb5;
        `SNR_OP_QOUT3:  dec_read = 8'h82;
        `SNR_OP_QOUT4:  dec_read = 8'ha2;
        `SNR_OP_DQOUT3: dec_read = 8'h92;
        `SNR_OP_QIO3:   dec_read = 8'h8a;
        `SNR_OP_QIO4:   dec_read = 8'haa;
        `SNR_OP_DQIO3:  dec_read = 8'h9a;
        `SNR_OP_DQIO4:  dec_read = 8'hba;
        default:        dec_read = 8'h00;
      endcase
    end
  endfunction

  function is_reg_rd;
    input [7:0] c;
    begin
      is_reg_rd = (c == `SNR_OP_RD_STAT) || (c == `SNR_OP_RD_FLAG) ||
                  (c == `SNR_OP_RD_NVC)  || (c == `SNR_OP_RD_VC)   ||
                  (c == `SNR_OP_RD_EVC)  || (c == `SNR_OP_RD_EXTA);
    end
  endfunction

  function is_ctl;
    input [7:0] c;
    begin
      is_ctl = (c == `SNR_OP_WR_EN) || (c == `SNR_OP_WR_DIS) ||
               (c == `SNR_OP_ADDR4_ON) || (c == `SNR_OP_ADDR4_OFF);
    end
  endfunction

  function [1:0] lmax;
    input [1:0] a;
    input [1:0] b;
    begin
      lmax = (a > b) ? a : b;
    end
  endfunction

  // Byte to shift out next; status values are live so polling sees progress
  function [7:0] src_byte;
    input [7:0] c;
    input [1:0] idx;
    begin
      case (c)
        `SNR_OP_RD_STAT: src_byte = STATUS_REG;
        `SNR_OP_RD_FLAG: src_byte = FLAG_REG;
        `SNR_OP_RD_VC:   src_byte = VC_REG;
        `SNR_OP_RD_EVC:  src_byte = EVC_REG;
        `SNR_OP_RD_EXTA: src_byte = EXTA_REG;
        `SNR_OP_RD_NVC:  src_byte = (idx == 2'd0) ? nvc_val[7:0] :
                                    (idx == 2'd1) ? nvc_val[15:8] : 8'h00;
        default:         src_byte = MEM_DATA;
      endcase
    end
  endfunction

  wire [7:0] dec_now = dec_read(next_sh[7:0]);

  // Input shifter, lane count set by the current phase
  always @* begin
    case (in_l)
      2'd0:    next_sh = {in_sh[30:0], serial_lane_zero};
      2'd1:    next_sh = {in_sh[29:0], lane_s[1:0]};
      default: next_sh = {in_sh[27:0], lane_s[3:0]};
    endcase
  end

  // Output lanes: single lane answers on lane one
  always @* begin
    case (o_l)
      2'd0: begin
        drv         = {2'b00, out_sh[7], 1'b0};
        oe_n        = 4'b1101;
        next_out_sh = {out_sh[6:0], 1'b0};
      end
      2'd1: begin
        drv         = {2'b00, out_sh[7:6]};
        oe_n        = 4'b1100;
        next_out_sh = {out_sh[5:0], 2'b00};
      end
      default: begin
        drv         = out_sh[7:4];
        oe_n        = 4'b0000;
        next_out_sh = {out_sh[3:0], 4'h0};
      end
    endcase
  end

  // Latch commands act only on select rising right after eight bits; set wins
  always @* begin
    next_wel = WEL;
    if (FLAG_CLEAR)
      next_wel = 1'b0;
    if (cs_rise && armed && cmd == `SNR_OP_WR_DIS && !PROT_ERR)
      next_wel = 1'b0;
    if (cs_rise && armed && cmd == `SNR_OP_WR_EN)
      next_wel = 1'b1;
  end

  always @(posedge CLOCK) begin
    if (!RST_N) begin
      state      <= ST_CMD;
      sclk_d     <= 1'b0;
      cs_n_d     <= 1'b1;
      in_sh      <= 32'h0;
      bit_cnt    <= 6'h0;
      cmd        <= 8'h00;
      a_l        <= 2'd0;
      o_l        <= 2'd0;
      ddr        <= 1'b0;
      mem_rd     <= 1'b0;
      alen       <= `SNR_ADDR_BITS3;
      dummy_cnt  <= 8'h00;
      out_sh     <= 8'h00;
      out_cnt    <= 4'h0;
      byte_idx   <= 2'd0;
      reload     <= 1'b0;
      started    <= 1'b0;
      armed      <= 1'b0;
      strap_load <= 1'b1;
      LANE_OUT   <= 4'h0;
      LANE_OE_N  <= 4'hf;
      MEM_ADDR   <= 32'h0;
      WEL        <= 1'b0;
      ADDR4_MODE <= 1'b0;
    end else begin
      sclk_d     <= sclk_s;
      cs_n_d     <= cs_n_s;
      WEL        <= next_wel;
      strap_load <= 1'b0;
      // Nonvolatile bit low selects four-byte addressing after reset
      if (strap_load)
        ADDR4_MODE <= ~NVC_REG[`SNR_NVC_ADDR_BIT];
      else if (cs_rise && armed && cmd == `SNR_OP_ADDR4_ON)
        ADDR4_MODE <= 1'b1;
      else if (cs_rise && armed && cmd == `SNR_OP_ADDR4_OFF)
        ADDR4_MODE <= 1'b0;
      if (cs_n_s) begin
        // Deselect ends everything, including output drive
        state     <= ST_CMD;
        LANE_OE_N <= 4'hf;
        in_sh     <= 32'h0;
        bit_cnt   <= 6'h0;
        armed     <= 1'b0;
        reload    <= 1'b0;
        started   <= 1'b0;
      end else begin
        case (state)
          ST_CMD: begin
            if (cmd_edge) begin
              in_sh   <= next_sh;
              bit_cnt <= bits_now;
              if (bits_now == 6'd8) begin
                cmd     <= next_sh[7:0];
                in_sh   <= 32'h0;
                bit_cnt <= 6'h0;
                if (dec_now[7]) begin
                  state  <= ST_ADDR;
                  mem_rd <= 1'b1;
                  a_l    <= lmax(cw_l, dec_now[3:2]);
                  o_l    <= lmax(cw_l, dec_now[1:0]);
                  ddr    <= dec_now[4] | DTR_EN;
                  alen   <= (dec_now[5] | ADDR4_MODE) ? `SNR_ADDR_BITS4
                                                      : `SNR_ADDR_BITS3;
                  dummy_cnt <= dec_now[6] ? 8'h00 : DUMMY_N;
                end else if (is_reg_rd(next_sh[7:0])) begin
                  state    <= ST_OUT;
                  mem_rd   <= 1'b0;
                  o_l      <= cw_l;
                  ddr      <= DTR_EN;
                  reload   <= 1'b1;
                  byte_idx <= 2'd0;
                  started  <= 1'b0;
                end else if (is_ctl(next_sh[7:0])) begin
                  state <= ST_HOLD;
                  armed <= 1'b1;
                end else begin
                  state <= ST_IGNORE;
                end
              end
            end
          end
          ST_ADDR: begin
            if (addr_edge) begin
              in_sh   <= next_sh;
              bit_cnt <= bits_now;
              if (bits_now == alen) begin
                MEM_ADDR <= next_sh;
                byte_idx <= 2'd0;
                started  <= 1'b0;
                if (dummy_cnt == 8'h00) begin
                  state  <= ST_OUT;
                  reload <= 1'b1;
                end else begin
                  state <= ST_DUMMY;
                end
              end
            end
          end
          ST_DUMMY: begin
            if (samp_rise) begin
              dummy_cnt <= dummy_cnt - 8'h01;
              if (dummy_cnt == 8'h01) begin
                state  <= ST_OUT;
                reload <= 1'b1;
              end
            end
          end
          ST_OUT: begin
            // Reload runs one cycle after the address moves, so array data has settled
            if (reload) begin
              out_sh  <= src_byte(mem_rd ? 8'h00 : cmd, byte_idx);
              out_cnt <= 4'h0;
              reload  <= 1'b0;
            end else if (out_edge) begin
              LANE_OUT  <= drv;
              LANE_OE_N <= oe_n;
              out_sh    <= next_out_sh;
              started   <= 1'b1;
              if (out_cnt + out_w == 4'd8) begin
                reload <= 1'b1;
                if (byte_idx != 2'd3)
                  byte_idx <= byte_idx + 2'd1;
                if (mem_rd)
                  MEM_ADDR <= MEM_ADDR + 32'h1;
              end else begin
                out_cnt <= out_cnt + out_w;
              end
            end
          end
          ST_HOLD: begin
            // Any clocking past the eighth bit cancels the latch command
            if (cmd_edge) begin
              armed <= 1'b0;
              state <= ST_IGNORE;
            end
          end
          ST_IGNORE: begin
            state <= ST_IGNORE;
          end
          default: begin
            state <= ST_IGNORE;
          end
        endcase
      end
    end
  end
endmodule // snr_cmd_front

// File: tb/snr_cmd_front_props.sv
// Checker for the serial NOR command front end
`timescale 1ns/10ps
module snr_cmd_front_props (
  // Clock and reset
  input wire        CLOCK,
  input wire        RST_N,
  // Observed ports
  input wire        CS_N,
  input wire [1:0]  PROTO_MODE,
  input wire [15:0] NVC_REG,
  input wire        PROT_ERR,
  input wire        FLAG_CLEAR,
  input wire [3:0]  LANE_OE_N,
  input wire [31:0] MEM_ADDR,
  input wire        WEL,
  input wire        ADDR4_MODE
);
  default clocking cb @(posedge CLOCK); endclocking
  default disable iff (!RST_N);

  AST_ADDR4_BOOT: assert property ($rose(RST_N) |-> ##3 ADDR4_MODE == !NVC_REG[0])
    else $error("address width after reset wrong");
  AST_SILENT_CMD: assert property ($fell(CS_N) |-> (LANE_OE_N == 4'hf) [*8])
    else $error("lanes driven in command phase");
  AST_OE_DESELECT: assert property (LANE_OE_N != 4'hf |-> !$past(CS_N, 4))
    else $error("lanes driven while deselected");
  AST_EXT_LANES: assert property (PROTO_MODE == 2'd0 && LANE_OE_N != 4'hf
    |-> LANE_OE_N inside {4'hd, 4'hc, 4'h0})
    else $error("wrong lanes in extended mode");
  AST_DUAL_LANES: assert property (PROTO_MODE == 2'd1 && LANE_OE_N != 4'hf
    |-> LANE_OE_N == 4'hc)
    else $error("wrong lanes in dual mode");
  AST_QUAD_LANES: assert property (PROTO_MODE == 2'd2 && LANE_OE_N != 4'hf
    |-> LANE_OE_N == 4'h0)
    else $error("wrong lanes in quad mode");
  AST_WEL_SET: assert property ($rose(WEL) |-> $past(CS_N, 2))
    else $error("latch set while selected");
  AST_WEL_CLR: assert property ($fell(WEL) |-> !$past(PROT_ERR) || $past(FLAG_CLEAR)
    || $past(FLAG_CLEAR, 2) || $past(FLAG_CLEAR, 3))
    else $error("latch cleared despite error");
  AST_WEL_HELD: assert property (!CS_N [*8] ##0 !FLAG_CLEAR |-> $stable(WEL))
    else $error("latch changed inside a frame");
  AST_ADDR_STEP: assert property (!CS_N && LANE_OE_N != 4'hf && $past(LANE_OE_N) != 4'hf
    && $changed(MEM_ADDR) |-> MEM_ADDR == $past(MEM_ADDR) + 32'h1)
    else $error("address did not step by one");
endmodule // snr_cmd_front_props

bind snr_cmd_front snr_cmd_front_props u_props (
  .CLOCK(CLOCK), .RST_N(RST_N), .CS_N(CS_N), .PROTO_MODE(PROTO_MODE),
  .NVC_REG(NVC_REG), .PROT_ERR(PROT_ERR), .FLAG_CLEAR(FLAG_CLEAR),
  .LANE_OE_N(LANE_OE_N), .MEM_ADDR(MEM_ADDR), .WEL(WEL), .ADDR4_MODE(ADDR4_MODE)
);

// File: tb/snr_host_model.sv
// Host serial controller driving select, serial clock and lanes
`timescale 1ns/10ps
module snr_host_model (
  // Clock
  input  wire       CLOCK,
  // Serial link
  output reg        SCLK,
  output reg        CS_N,
  output reg  [3:0] LANE_IN,
  input  wire [3:0] LANE_OUT,
  input  wire [3:0] LANE_OE_N
);
  reg [3:0] got;
  reg [3:0] got_lo;

  initial begin
    SCLK = 1'b0;
    CS_N = 1'b1;
    LANE_IN = 4'h0;
    got = 4'h0;
    got_lo = 4'h0;
  end

  // Data moves on the fall, held over the rise; output sampled before the rise
  task tick(input [3:0] v);
    begin
      LANE_IN <= v;
      repeat (6) @(posedge CLOCK);
      // Undriven lanes read back inverted so a missing enable shows
      got = LANE_OUT ^ LANE_OE_N;
      SCLK <= 1'b1;
      repeat (6) @(posedge CLOCK);
      SCLK <= 1'b0;
    end
  endtask

  // Double rate clock: lanes move mid-phase, away from both edges
  task dtick(input [3:0] hi, input [3:0] lo);
    begin
      LANE_IN <= hi;
      repeat (6) @(posedge CLOCK);
      got = LANE_OUT ^ LANE_OE_N;
      SCLK <= 1'b1;
      repeat (3) @(posedge CLOCK);
      LANE_IN <= lo;
      repeat (3) @(posedge CLOCK);
      got_lo = LANE_OUT ^ LANE_OE_N;
      SCLK <= 1'b0;
      repeat (3) @(posedge CLOCK);
    end
  endtask

  task sel;
    begin
      @(posedge CLOCK);
      CS_N <= 1'b0;
      repeat (4) @(posedge CLOCK);
    end
  endtask

  // Select rises with no further serial edge
  task desel;
    begin
      repeat (2) @(posedge CLOCK);
      CS_N <= 1'b1;
      repeat (8) @(posedge CLOCK);
    end
  endtask

  task send(input [31:0] v, input integer nb, input integer nl);
    integer i;
    begin
      for (i = nb - nl; i >= 0; i = i - nl)
        tick(nl == 4 ? v[i +: 4] : nl == 2 ? {2'b00, v[i +: 2]} : {3'b000, v[i]});
    end
  endtask
endmodule // snr_host_model

// File: tb/snr_cmd_front_tb_top.sv
// Self-checking bench for the serial NOR command front end
`timescale 1ns/10ps
`include "snr_regs.vh"
module snr_cmd_front_tb_top;
  localparam [15:0] RSVD = 16'h0300;
  reg         clock;
  reg         rst_n;
  reg  [1:0]  proto_mode;
  reg         prot_err;
  reg         flag_clear;
  reg  [7:0]  status_reg;
  reg  [15:0] nvc_reg;
  reg         dtr_en;
  reg  [7:0]  flag_reg;
  wire        sclk;
  wire        cs_n;
  wire [3:0]  lane_in;
  wire [3:0]  lane_out;
  wire [3:0]  lane_oe_n;
  wire [31:0] mem_addr;
  wire [7:0]  mem_data;
  wire        wel;
  wire        addr4_mode;
  integer     n_fail;
  integer     tests_run;
  reg  [7:0]  b;

  always #25 clock = ~clock;
  // Array stand-in: byte is a fixed mix of its address
  assign mem_data = mem_addr[7:0] ^ 8'h5a;

  snr_host_model h (.CLOCK(clock), .SCLK(sclk), .CS_N(cs_n), .LANE_IN(lane_in),
    .LANE_OUT(lane_out), .LANE_OE_N(lane_oe_n));
  snr_cmd_front #(.DUMMY_CLKS(8), .NVC_RSVD(RSVD)) DUT (
    .CLOCK(clock), .RST_N(rst_n), .SCLK(sclk), .CS_N(cs_n), .LANE_IN(lane_in),
    .LANE_OUT(lane_out), .LANE_OE_N(lane_oe_n), .PROTO_MODE(proto_mode), .DTR_EN(dtr_en),
    .STATUS_REG(status_reg), .FLAG_REG(flag_reg), .NVC_REG(nvc_reg), .VC_REG(8'hfb),
    .EVC_REG(8'hdf), .EXTA_REG(8'h03), .PROT_ERR(prot_err), .FLAG_CLEAR(flag_clear),
    .MEM_ADDR(mem_addr), .MEM_DATA(mem_data), .WEL(wel), .ADDR4_MODE(addr4_mode));

  task chk(input [31:0] e, input [31:0] g, input string nm);
    begin
      tests_run = tests_run + 1;
      if (e !== g) begin
        n_fail = n_fail + 1;
        $display("[FAIL] %s expected %h seen %h", nm, e, g);
      end
    end
  endtask

  function integer nl_of(input [1:0] m);
    nl_of = m == 2'd1 ? 2 : m == 2'd2 ? 4 : 1;
  endfunction

  task op(input [7:0] c, input integer extra);
    begin
      h.sel;
      h.send({24'h0, c}, 8, nl_of(proto_mode));
      if (extra)
        h.tick(4'h0);
      h.desel;
    end
  endtask

  task rd(input integer nl, output [7:0] bo);
    integer k;
    begin
      for (k = 0; k < 8 / nl; k = k + 1) begin
        h.tick(4'h9 ^ k[3:0]);
        bo = nl == 1 ? {bo[6:0], h.got[1]} : nl == 2 ? {bo[5:0], h.got[1:0]} : {bo[3:0], h.got};
      end
    end
  endtask

  task t_addr4;
    begin
      chk(0, addr4_mode, "default width");
      op(`SNR_OP_ADDR4_ON, 0);
      chk(1, addr4_mode, "width on");
      op(`SNR_OP_ADDR4_OFF, 0);
      chk(0, addr4_mode, "width off");
    end
  endtask

  task t_latch;
    begin
      op(`SNR_OP_WR_EN, 1);
      chk(0, wel, "late select");
      op(`SNR_OP_WR_EN, 0);
      chk(1, wel, "enable");
      prot_err <= 1'b1;
      op(`SNR_OP_WR_DIS, 0);
      chk(1, wel, "held by error");
      flag_clear <= 1'b1;
      @(posedge clock);
      flag_clear <= 1'b0;
      prot_err <= 1'b0;
      repeat (6) @(posedge clock);
      chk(0, wel, "flag clear");
      proto_mode <= 2'd1;
      op(`SNR_OP_WR_EN, 0);
      chk(1, wel, "dual enable");
      proto_mode <= 2'd2;
      op(`SNR_OP_WR_DIS, 0);
      chk(0, wel, "quad disable");
      proto_mode <= 2'd0;
    end
  endtask

  task t_read;
    integer i;
    integer k;
    reg [7:0]  c;
    reg [31:0] a;
    reg [31:0] e;
    integer ab, al, ol, dm;
    begin
      for (i = 0; i < 7; i = i + 1) begin
        case (i)
          0: begin c = `SNR_OP_READ3; ab = 24; al = 1; ol = 1; dm = 0; end
          1: begin c = `SNR_OP_READ4; ab = 32; al = 1; ol = 1; dm = 0; end
          2: begin c = `SNR_OP_FAST4; ab = 32; al = 1; ol = 1; dm = 8; end
          3: begin c = `SNR_OP_DOUT4; ab = 32; al = 1; ol = 2; dm = 8; end
          4: begin c = `SNR_OP_QOUT4; ab = 32; al = 1; ol = 4; dm = 8; end
          5: begin c = `SNR_OP_DIO4; ab = 32; al = 2; ol = 2; dm = 8; end
          default: begin c = `SNR_OP_QIO4; ab = 32; al = 4; ol = 4; dm = 8; end
        endcase
        a = {4'h7, i[3:0], 24'h3a41fe};
        e = ab == 32 ? a : {8'h00, a[23:0]};
        h.sel;
        h.send({24'h0, c}, 8, 1);
        h.send(a, ab, al);
        for (k = 0; k < dm; k = k + 1)
          h.tick(4'h6 ^ k[3:0]);
        repeat (4) @(posedge clock);
        chk(e, mem_addr, "start address");
        rd(ol, b);
        chk(a[7:0] ^ 8'h5a, b, "first byte");
        rd(ol, b);
        chk((a[7:0] + 8'h01) ^ 8'h5a, b, "second byte");
        h.desel;
        chk(e + 32'h2, mem_addr, "address step");
      end
    end
  endtask

  task t_regs;
    integer i;
    reg [7:0] c, e0, e1, e2;
    begin
      for (i = 0; i < 8; i = i + 1) begin
        status_reg <= 8'h02;
        proto_mode <= i == 6 ? 2'd1 : i == 7 ? 2'd2 : 2'd0;
        case (i)
          // Next byte is fetched while the last bit (last pair in dual) of the current one is clocked
          0, 6: begin c = `SNR_OP_RD_STAT; e0 = 8'h02; e1 = 8'h02; e2 = 8'h03; end
          1, 7: begin c = `SNR_OP_RD_FLAG; e0 = 8'h81; e1 = 8'h81; e2 = 8'h81; end
          2: begin c = `SNR_OP_RD_NVC; e0 = nvc_reg[7:0] | RSVD[7:0];
            e1 = nvc_reg[15:8] | RSVD[15:8]; e2 = 8'h00; end
          3: begin c = `SNR_OP_RD_VC; e0 = 8'hfb; e1 = 8'hfb; e2 = 8'hfb; end
          4: begin c = `SNR_OP_RD_EVC; e0 = 8'hdf; e1 = 8'hdf; e2 = 8'hdf; end
          default: begin c = `SNR_OP_RD_EXTA; e0 = 8'h03; e1 = 8'h03; e2 = 8'h03; end
        endcase
        h.sel;
        h.send({24'h0, c}, 8, nl_of(proto_mode));
        rd(nl_of(proto_mode), b);
        chk(e0, b, "register byte 0");
        status_reg <= 8'h03;
        rd(nl_of(proto_mode), b);
        chk(e1, b, "register byte 1");
        rd(nl_of(proto_mode), b);
        chk(e2, b, "register byte 2");
        h.desel;
      end
      proto_mode <= 2'd0;
    end
  endtask

  task t_ddr;
    integer k;
    reg [31:0] a;
    begin
      a = 32'h1c0f3e7d;
      h.sel;
      h.send({24'h0, `SNR_OP_DQIO4}, 8, 1);
      for (k = 28; k > 0; k = k - 8)
        h.dtick(a[k +: 4], a[k - 4 +: 4]);
      for (k = 0; k < 8; k = k + 1)
        h.tick(4'h0);
      chk(a, mem_addr, "double rate address");
      h.dtick(4'h0, 4'h0);
      chk(a[7:0] ^ 8'h5a, {h.got, h.got_lo}, "double rate byte");
      h.desel;
      chk(a + 32'h1, mem_addr, "double rate step");
    end
  endtask

  task t_abort;
    begin
      h.sel;
      h.send({24'h0, `SNR_OP_RD_STAT}, 8, 1);
      rd(2, b);
      chk(4'hd, lane_oe_n, "driving lane one");
      h.desel;
      chk(4'hf, lane_oe_n, "released after select");
    end
  endtask

  task conclude;
    begin
      $display("checks %0d mismatches %0d", tests_run, n_fail);
      if (n_fail == 0 && tests_run > 0)
        $display("[ PASS ]");
      else
        $display("[ FAIL ]");
      $finish;
    end
  endtask

  initial begin
    #2000000;
    n_fail = n_fail + 1;
    conclude;
  end

  initial begin
    clock = 1'b0;
    rst_n = 1'b0;
    proto_mode = 2'd0;
    prot_err = 1'b0;
    flag_clear = 1'b0;
    status_reg = 8'h02;
    nvc_reg = 16'hd1f1;
    dtr_en = 1'b0;
    flag_reg = 8'h81;
    n_fail = 0;
    tests_run = 0;
    repeat (10) @(posedge clock);
    rst_n <= 1'b1;
    repeat (6) @(posedge clock);
    t_addr4;
    t_latch;
    t_read;
    t_regs;
    t_ddr;
    t_abort;
    conclude;
  end
endmodule // snr_cmd_front_tb_top
